// [rtl/qfo_map.svh]
// register offsets, reset values and timing counts of the quadrature feedback output
// assumes inclusion by name from the design files, no other dependency
`ifndef QFO_MAP_SVH
`define QFO_MAP_SVH

// register byte offsets, one aligned word each
`define QFO_REG_RES        8'h00
`define QFO_REG_LEAD       8'h04
`define QFO_REG_VLIM       8'h08
`define QFO_REG_EDGES      8'h0c
`define QFO_REG_STATUS     8'h10

// field positions
`define QFO_LEAD_BIT       0
`define QFO_STATUS_BUSY    0

// resolution setting, total a/b edges per revolution
`define QFO_RES_RESET      23'd81920
`define QFO_RES_MAX        23'd5242880
`define QFO_LEAD_RESET     1'b0

// internal position counts per revolution and per reference pulse (80 per revolution)
`define QFO_POS_PER_REV    24'd2621440
`define QFO_Z_PER_REV      24'd80
`define QFO_POS_PER_Z      (`QFO_POS_PER_REV / `QFO_Z_PER_REV)
`define QFO_Z_WIDTH        16'd256

// edge rate ceiling and clock
`define QFO_MAX_EDGE_HZ    3125000
`define QFO_CLK_HZ         100000000
`define QFO_EDGE_GAP_CYC   ((`QFO_CLK_HZ + `QFO_MAX_EDGE_HZ - 1) / `QFO_MAX_EDGE_HZ)

// velocity limit in 0.001 rev/s: min(ceiling, edge rate * 1000 / resolution)
`define QFO_VLIM_NUM       32'd3125000000
`define QFO_VLIM_CEIL      32'd10000
`define QFO_VLIM_RESET     32'd10000

`endif

// [rtl/qfo_pkg.sv]
// types of the quadrature feedback output
// assumes qfo_map.svh for all numeric constants
package qfo_pkg;

   // divider sequencer, one bit changes per step except done back to idle
   typedef enum logic [1:0] {
      QFO_DIV_IDLE = 2'b00,
      QFO_DIV_RUN  = 2'b01,
      QFO_DIV_DONE = 2'b11
   } qfo_div_state_t;

   typedef logic [1:0] qfo_phase_t;

endpackage : qfo_pkg

// [rtl/qfo_top.sv]
// quadrature feedback output: a/b/z generation from internal position steps,
// resolution and leading phase registers, velocity limit and signed edge count
// assumes pos_step/pos_dir/home_set come from logic on sys_clk, register master on sys_clk
//
// Notes on behaviour
// - after reset the resolution is 81920 a/b edges per revolution, 20480 per phase.
// - a resolution write of 0 to 5242880 is accepted; larger values are ignored.
// - exactly 80 z pulses come out per revolution whatever the resolution.
// - a/b edges are spaced so the combined rate never passes 3125000 per second, except when a lead select write swaps a and b.
// - the resolution sets edges per revolution and a separate bit picks the leading phase.
// - with lead select 0 phase a leads clockwise, with 1 phase b leads clockwise.
// - a resolution of zero stops all a/b edges except those of a lead select write swapping a and b.
// - the fractional residue is accumulated and referred to the home position.
// - each accepted resolution write recomputes the velocity limit from the edge rate ceiling.
// - the requested move speed is clamped to the velocity limit.
// - the z rising edge sits at the same position in both directions.
// - a, b and z are not aligned to each other; the receiver treats them separately.
// - a signed 32-bit count of emitted edges is kept and readable.
//
// The implementer's own choices: the register offsets and the plain strobed port.
`include "qfo_map.svh"

module qfo_top (
   input  wire logic        sys_clk,
   input  wire logic        reset_n,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        pos_step,
   input  wire logic        pos_dir,
   input  wire logic        home_set,
   input  wire logic [31:0] move_speed_req,
   output logic      [31:0] move_speed_out,
   output logic             phase_a_out,
   output logic             phase_a_n_out,
   output logic             phase_b_out,
   output logic             phase_b_n_out,
   output logic             reference_phase_out,
   output logic             reference_phase_n_out
);

   localparam logic [5:0]  EDGE_GAP = 6'(`QFO_EDGE_GAP_CYC);
   localparam logic [23:0] POS_REV  = `QFO_POS_PER_REV;
   localparam logic [23:0] POS_Z    = 24'(`QFO_POS_PER_Z);

   logic [22:0]              feedback_resolution_q;
   logic                     leading_phase_select_q;
   logic [31:0]              velocity_limit_q;
   logic [31:0]              feedback_edge_count_q;
   logic [23:0]              resid_q;
   logic [23:0]              resid_d;
   logic signed [3:0]        pend_q;
   logic signed [3:0]        pend_d;
   logic [5:0]               gap_q;
   qfo_pkg::qfo_phase_t      phase_q;
   logic [23:0]              zpos_q;
   logic [15:0]              zrem_q;
   logic                     z_q;
   qfo_pkg::qfo_div_state_t  div_state_q;
   logic [31:0]              div_num_q;
   logic [32:0]              div_rem_q;
   logic [31:0]              div_quo_q;
   logic [5:0]               div_cnt_q;
   logic [31:0]              rdata_q;
   logic                     a_q;
   logic                     b_q;
   logic [31:0]              speed_q;

   // register decode
   wire        sel_res    = (reg_addr == `QFO_REG_RES);
   wire        sel_lead   = (reg_addr == `QFO_REG_LEAD);
   wire        sel_vlim   = (reg_addr == `QFO_REG_VLIM);
   wire        sel_edges  = (reg_addr == `QFO_REG_EDGES);
   wire        sel_status = (reg_addr == `QFO_REG_STATUS);
   wire        res_ok     = (reg_wdata <= {9'h000, `QFO_RES_MAX});
   wire        wr_res     = reg_wr && sel_res && res_ok;
   wire        div_busy   = (div_state_q != qfo_pkg::QFO_DIV_IDLE);
   wire [31:0] rd_mux     = sel_res    ? {9'h000, feedback_resolution_q} :
                            sel_lead   ? {31'h0, leading_phase_select_q} :
                            sel_vlim   ? velocity_limit_q :
                            sel_edges  ? feedback_edge_count_q :
                            sel_status ? {31'h0, div_busy} :
                                         32'h00000000;

   // register writes; lead select changes reach a and b two cycles after the write strobe, without waiting for an edge
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         feedback_resolution_q  <= `QFO_RES_RESET;
         leading_phase_select_q <= `QFO_LEAD_RESET;
      end else begin
         if (wr_res) begin
            feedback_resolution_q <= reg_wdata[22:0];
         end
         if (reg_wr && sel_lead) begin
            leading_phase_select_q <= reg_wdata[`QFO_LEAD_BIT];
         end
      end
   end

   // read data stands one cycle after the strobe and only then
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 32'h00000000;
      end
   end
   assign reg_rdata = rdata_q;

   // residue accumulator: resolution added per forward step and subtracted per reverse step, wrapping at one revolution
   wire [24:0] fwd_sum  = {1'b0, resid_q} + {2'b00, feedback_resolution_q};
   wire [24:0] fwd_one  = fwd_sum - {1'b0, POS_REV};
   wire [24:0] fwd_two  = fwd_sum - {POS_REV, 1'b0};
   wire [24:0] bwd_dif  = {1'b0, resid_q} - {2'b00, feedback_resolution_q};
   wire [24:0] bwd_one  = bwd_dif + {1'b0, POS_REV};
   wire [24:0] bwd_two  = bwd_dif + {POS_REV, 1'b0};
   logic signed [2:0] step_edges;
   always_comb begin
      resid_d    = resid_q;
      step_edges = 3'sd0;
      if (pos_step) begin
         if (pos_dir) begin
            if (!fwd_two[24]) begin
               resid_d    = fwd_two[23:0];
               step_edges = 3'sd2;
            end else if (!fwd_one[24]) begin
               resid_d    = fwd_one[23:0];
               step_edges = 3'sd1;
            end else begin
               resid_d    = fwd_sum[23:0];
            end
         end else begin
            if (!bwd_dif[24]) begin
               resid_d    = bwd_dif[23:0];
            end else if (!bwd_one[24]) begin
               resid_d    = bwd_one[23:0];
               step_edges = -3'sd1;
            end else begin
               resid_d    = bwd_two[23:0];
               step_edges = -3'sd2;
            end
         end
      end
   end

   // edge emission, at most one edge per gap; pending saturates at +-7
   wire        res_zero = (feedback_resolution_q == 23'h000000);
   wire        emit     = (pend_q != 4'sd0) && (gap_q == 6'h00) && !res_zero;
   wire        emit_fwd = emit && !pend_q[3];
   wire signed [4:0] pend_sum = 5'(pend_q) + 5'(step_edges)
                                - (emit ? (emit_fwd ? 5'sd1 : -5'sd1) : 5'sd0);
   always_comb begin
      if (res_zero) begin
         pend_d = 4'sd0;
      end else if (pend_sum > 5'sd7) begin
         pend_d = 4'sd7;
      end else if (pend_sum < -5'sd7) begin
         pend_d = -4'sd7;
      end else begin
         pend_d = pend_sum[3:0];
      end
   end

   // accumulator, pending edges and spacing; home re-references the residue
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         resid_q <= 24'h000000;
         pend_q  <= 4'sd0;
         gap_q   <= 6'h00;
      end else begin
         resid_q <= home_set ? 24'h000000 : resid_d;
         pend_q  <= home_set ? 4'sd0 : pend_d;
         if (emit) begin
            gap_q <= EDGE_GAP - 6'h01;
         end else if (gap_q != 6'h00) begin
            gap_q <= gap_q - 6'h01;
         end
      end
   end

   // quadrature phase counter and signed edge count
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         phase_q               <= 2'b00;
         feedback_edge_count_q <= 32'h00000000;
      end else if (emit) begin
         phase_q               <= emit_fwd ? phase_q + 2'b01 : phase_q - 2'b01;
         feedback_edge_count_q <= emit_fwd ? feedback_edge_count_q + 32'h00000001
                                           : feedback_edge_count_q - 32'h00000001;
      end
   end

   // phase a leads forward in the raw sequence; the select swaps the pair
   wire raw_lead = phase_q[0] ^ phase_q[1];
   wire raw_lag  = phase_q[1];
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         a_q <= 1'b0;
         b_q <= 1'b0;
      end else begin
         a_q <= leading_phase_select_q ? raw_lag : raw_lead;
         b_q <= leading_phase_select_q ? raw_lead : raw_lag;
      end
   end
   assign phase_a_out   = a_q;
   assign phase_a_n_out = ~a_q;
   assign phase_b_out   = b_q;
   assign phase_b_n_out = ~b_q;

   // reference phase: position within one z period, pulse opened on crossing zero
   // either way and closed after a fixed count, so only the rising edge is repeatable
   wire        z_fwd_cross = pos_step && pos_dir && (zpos_q == POS_Z - 24'h000001);
   wire        z_bwd_cross = pos_step && !pos_dir && (zpos_q == 24'h000000);
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         zpos_q <= 24'h000000;
         zrem_q <= 16'h0000;
         z_q    <= 1'b0;
      end else if (home_set) begin
         zpos_q <= 24'h000000;
         zrem_q <= 16'h0000;
         z_q    <= 1'b0;
      end else if (pos_step) begin
         if (pos_dir) begin
            zpos_q <= z_fwd_cross ? 24'h000000 : zpos_q + 24'h000001;
         end else begin
            zpos_q <= z_bwd_cross ? POS_Z - 24'h000001 : zpos_q - 24'h000001;
         end
         if (z_fwd_cross || z_bwd_cross) begin
            z_q    <= 1'b1;
            zrem_q <= `QFO_Z_WIDTH - 16'h0001;
         end else if (zrem_q != 16'h0000) begin
            zrem_q <= zrem_q - 16'h0001;
         end else begin
            z_q    <= 1'b0;
         end
      end
   end
   // z runs off the position steps, not the edge pacer, so it is not aligned to a/b
   assign reference_phase_out   = z_q;
   assign reference_phase_n_out = ~z_q;

   // velocity limit: restoring divide of the rate ceiling by the resolution, rerun on write
   wire [32:0] div_try = {div_rem_q[31:0], div_num_q[31]};
   wire [32:0] div_sub = div_try - {10'h000, feedback_resolution_q};
   wire        div_fit = !div_sub[32];
   wire [31:0] vlim_res = (div_quo_q > `QFO_VLIM_CEIL) ? `QFO_VLIM_CEIL : div_quo_q;
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         div_state_q      <= qfo_pkg::QFO_DIV_IDLE;
         div_num_q        <= 32'h00000000;
         div_rem_q        <= 33'h0;
         div_quo_q        <= 32'h00000000;
         div_cnt_q        <= 6'h00;
         velocity_limit_q <= `QFO_VLIM_RESET;
      end else if (wr_res) begin
         div_state_q <= qfo_pkg::QFO_DIV_RUN;
         div_num_q   <= `QFO_VLIM_NUM;
         div_rem_q   <= 33'h0;
         div_quo_q   <= 32'h00000000;
         div_cnt_q   <= 6'h00;
      end else begin
         case (div_state_q)
            qfo_pkg::QFO_DIV_IDLE: begin
               div_cnt_q <= 6'h00;
            end
            qfo_pkg::QFO_DIV_RUN: begin
               div_num_q <= {div_num_q[30:0], 1'b0};
               div_rem_q <= div_fit ? div_sub : div_try;
               div_quo_q <= {div_quo_q[30:0], div_fit};
               div_cnt_q <= div_cnt_q + 6'h01;
               if (div_cnt_q == 6'd31) begin
                  div_state_q <= qfo_pkg::QFO_DIV_DONE;
               end
            end
            qfo_pkg::QFO_DIV_DONE: begin
               // zero resolution emits nothing, so the ceiling alone applies
               velocity_limit_q <= res_zero ? `QFO_VLIM_CEIL : vlim_res;
               div_state_q      <= qfo_pkg::QFO_DIV_IDLE;
            end
            default: begin
               div_state_q <= qfo_pkg::QFO_DIV_IDLE;
            end
         endcase
      end
   end

   // move speed clamp; the pulse train source is trusted to stay below the limit
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         speed_q <= 32'h00000000;
      end else begin
         speed_q <= (move_speed_req > velocity_limit_q) ? velocity_limit_q
                                                        : move_speed_req;
      end
   end
   assign move_speed_out = speed_q;

endmodule : qfo_top

// [tb/qfo_master.sv]
// master controller model: decodes a/b into a position and counts z rises
// assumes registered phases from the block, sampled on sys_clk
module qfo_master (
   input  wire logic sys_clk,
   input  wire logic reset_n,
   input  wire logic phase_a,
   input  wire logic phase_b,
   input  wire logic ref_z,
   output int        pos_count,
   output int        z_rises,
   output int        bad_moves
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] idx_q;
   logic       z_q;
   // each phase decoded on its own sample, no alignment with z assumed
   wire  [1:0] idx  = {phase_b, phase_a ^ phase_b};
   wire  [1:0] diff = idx - idx_q;
   // quarter steps of the gray pair, a jump of two is a fault
   always @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         idx_q     <= 2'b00;
         z_q       <= 1'b0;
         pos_count <= 0;
         z_rises   <= 0;
         bad_moves <= 0;
      end else begin
         idx_q <= idx;
         z_q   <= ref_z;
         if (diff == 2'd1) pos_count <= pos_count + 1; // a leading counts up
         if (diff == 2'd3) pos_count <= pos_count - 1;
         if (diff == 2'd2) bad_moves <= bad_moves + 1;
         if (ref_z && !z_q) z_rises <= z_rises + 1; // only the rise marks the reference
      end
   end
endmodule : qfo_master

// [tb/qfo_props.sv]
// checker for the quadrature feedback output, top ports only
// assumes one sys_clk domain and the offsets of qfo_map.svh
`include "qfo_map.svh"
module qfo_props (
   input wire logic        sys_clk,
   input wire logic        reset_n,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        pos_step,
   input wire logic [31:0] move_speed_req,
   input wire logic [31:0] move_speed_out,
   input wire logic        phase_a_out,
   input wire logic        phase_a_n_out,
   input wire logic        phase_b_out,
   input wire logic        phase_b_n_out,
   input wire logic        reference_phase_out,
   input wire logic        reference_phase_n_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       a_q;
   logic       b_q;
   logic [5:0] gap_q;
   // an a/b edge is any change against last cycle's level
   wire        a_edge  = phase_a_out != a_q;
   wire        b_edge  = phase_b_out != b_q;
   wire        ab_edge = a_edge || b_edge;
   wire  [5:0] gap_d   = ab_edge ? 6'h00 : gap_q + {5'h00, gap_q != 6'h3f};
   // cycles since the last edge, saturating so idle never wraps
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         a_q   <= 1'b0;
         b_q   <= 1'b0;
         gap_q <= 6'h3f;
      end else begin
         a_q   <= phase_a_out;
         b_q   <= phase_b_out;
         gap_q <= gap_d;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   edge_gap_a: assert property (ab_edge |-> gap_q >= 6'd31)
      else $error("a/b edges closer than the rate allows");
   one_phase_a: assert property (!(a_edge && b_edge))
      else $error("both phases moved at once");
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
      else $error("read data outside the read cycle");
   vlim_range_a: assert property (reg_rd && reg_addr == `QFO_REG_VLIM
      |=> reg_rdata inside {[32'h1:`QFO_VLIM_CEIL]}) else $error("velocity limit out of range");
   speed_ceil_a: assert property (move_speed_out <= `QFO_VLIM_CEIL)
      else $error("move speed above ceiling");
   speed_req_a: assert property (move_speed_out <= $past(move_speed_req))
      else $error("move speed above request");
   z_cause_a: assert property ($rose(reference_phase_out) |-> $past(pos_step))
      else $error("reference rose without a step");
   line_pair_a: assert property ({phase_a_n_out, phase_b_n_out, reference_phase_n_out}
      == ~{phase_a_out, phase_b_out, reference_phase_out}) else $error("complement mismatch");
endmodule : qfo_props

bind qfo_top qfo_props qfo_props_i (.sys_clk(sys_clk), .reset_n(reset_n),
   .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pos_step(pos_step),
   .move_speed_req(move_speed_req), .move_speed_out(move_speed_out),
   .phase_a_out(phase_a_out), .phase_a_n_out(phase_a_n_out), .phase_b_out(phase_b_out),
   .phase_b_n_out(phase_b_n_out), .reference_phase_out(reference_phase_out),
   .reference_phase_n_out(reference_phase_n_out));

// [tb/test_quadrature_feedback_output.sv]
// self-checking bench for qfo_top with a pulse counting master
// assumes qfo_map.svh offsets and a 100 MHz sys_clk
`include "qfo_map.svh"
module test_quadrature_feedback_output;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk;
   logic        reset_n        = 1'b0;
   logic [7:0]  reg_addr       = 8'h00;
   logic [31:0] reg_wdata      = 32'h0;
   logic        reg_wr         = 1'b0;
   logic        reg_rd         = 1'b0;
   logic        pos_step       = 1'b0;
   logic        pos_dir        = 1'b0;
   logic        home_set       = 1'b0;
   logic [31:0] move_speed_req = 32'h0;
   logic [31:0] reg_rdata, move_speed_out;
   logic        a, a_n, b, b_n, z, z_n;
   int          pos_count, z_rises, bad_moves;
   int          errors = 0;
   int          num_checks = 0;
   int          cycles = 0;

   qfo_top qfo_top_i (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .pos_step(pos_step), .pos_dir(pos_dir), .home_set(home_set),
      .move_speed_req(move_speed_req), .move_speed_out(move_speed_out),
      .phase_a_out(a), .phase_a_n_out(a_n), .phase_b_out(b), .phase_b_n_out(b_n),
      .reference_phase_out(z), .reference_phase_n_out(z_n));
   qfo_master qfo_master_i (.sys_clk(sys_clk), .reset_n(reset_n), .phase_a(a),
      .phase_b(b), .ref_z(z), .pos_count(pos_count), .z_rises(z_rises),
      .bad_moves(bad_moves));

   task stop_test;
      if (errors == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : stop_test

   task check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   task wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr  <= ad;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe
   task rd(input logic [7:0] ad, output logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= ad;
      reg_rd   <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   task rc(input logic [7:0] ad, input logic [31:0] e);
      logic [31:0] v;
      rd(ad, v);
      check(v, e);
   endtask : rc

   // poll the divider busy bit, bounded
   task idle;
      logic [31:0] v;
      v = 32'h1;
      for (int i = 0; i < 60 && v[0] !== 1'b0; i++) rd(`QFO_REG_STATUS, v);
      check(v, 32'h0);
   endtask : idle

   // gap 0 holds the step high for n back-to-back counts
   task step(input logic d, input int n, input int gap);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         pos_step <= 1'b1;
         pos_dir  <= d;
         if (gap > 0) begin
            @(posedge sys_clk);
            pos_step <= 1'b0;
            repeat (gap) @(posedge sys_clk);
         end
      end
      @(posedge sys_clk);
      pos_step <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask : step

   task home;
      @(posedge sys_clk);
      home_set <= 1'b1;
      @(posedge sys_clk);
      home_set <= 1'b0;
   endtask : home

   task spd(input logic [31:0] r, input logic [31:0] e);
      @(posedge sys_clk);
      move_speed_req <= r;
      repeat (3) @(posedge sys_clk);
      #1;
      check(move_speed_out, e);
   endtask : spd

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // hang guard, the run needs about 34600 cycles
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 60000) begin
         errors++;
         stop_test;
      end
   end

   initial begin
      repeat (5) @(posedge sys_clk);
      reset_n <= 1'b1;
      rc(`QFO_REG_RES, 32'd81920);
      rc(`QFO_REG_LEAD, 32'h0);
      rc(`QFO_REG_VLIM, 32'd10000);
      rc(`QFO_REG_EDGES, 32'h0);
      rc(8'h14, 32'h0);
      wr(`QFO_REG_RES, 32'd2621440);
      idle;
      rc(`QFO_REG_VLIM, 32'd1192);
      // 42 cycles a step keeps the motor under the velocity limit
      step(1'b1, 8, 40);
      check(pos_count, 32'd8);
      wr(`QFO_REG_LEAD, 32'h1);
      step(1'b1, 4, 40);
      check(pos_count, 32'd4);
      step(1'b0, 4, 40);
      rc(`QFO_REG_EDGES, 32'd8);
      wr(`QFO_REG_LEAD, 32'h0);
      wr(`QFO_REG_RES, 32'd1310720);
      home;
      step(1'b1, 6, 40);
      check(pos_count, 32'd11);
      rc(`QFO_REG_EDGES, 32'd11);
      wr(`QFO_REG_RES, 32'h0);
      idle;
      rc(`QFO_REG_VLIM, 32'd10000);
      home;
      step(1'b1, 32767, 0);
      check(z_rises, 32'd0);
      step(1'b1, 1, 0);
      check(z_rises, 32'd1);
      step(1'b1, 300, 0);
      step(1'b0, 301, 0);
      check(z_rises, 32'd2);
      check(pos_count, 32'd11);
      rc(`QFO_REG_EDGES, 32'd11);
      wr(`QFO_REG_RES, 32'd5242881);
      rc(`QFO_REG_RES, 32'h0);
      wr(`QFO_REG_RES, 32'd5242880);
      idle;
      rc(`QFO_REG_RES, 32'd5242880);
      rc(`QFO_REG_VLIM, 32'd596);
      // burst of two steps queues four edges, so the pacer must space them itself
      step(1'b1, 2, 0);
      repeat (120) @(posedge sys_clk);
      check(pos_count, 32'd15);
      rc(`QFO_REG_EDGES, 32'd15);
      spd(32'd20000, 32'd596);
      spd(32'd100, 32'd100);
      check(bad_moves, 32'd0);
      stop_test;
   end
endmodule : test_quadrature_feedback_output
